// *** core/wts_pkg.sv ***
// Package of constants and types for the wireless transmit status sequencer
package wts_pkg;
  // Clock rate and derived counts
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned INIT_MS        = 500;
  localparam int unsigned FLASH_MS       = 1000;
  localparam int unsigned INIT_CYCLES    = CLK_HZ / 1000 * INIT_MS;
  localparam int unsigned HALF_FLASH_CYC = CLK_HZ / 1000 * FLASH_MS / 2;
  localparam int unsigned REQ_TIMEOUT_MS = 1500;
  localparam int unsigned REQ_TIMEOUT_CYC = CLK_HZ / 1000 * REQ_TIMEOUT_MS;
  localparam int unsigned CNT_W          = 32;
  localparam logic        FLASH_RESET    = 1'b0;

  // Sequencer states, Gray along init-standby-negotiate-charge-complete
  typedef enum logic [2:0] {
    WTS_INIT      = 3'h0,
    WTS_STANDBY   = 3'h1,
    WTS_NEGOTIATE = 3'h3,
    WTS_CHARGE    = 3'h2,
    WTS_COMPLETE  = 3'h6,
    WTS_FOD_FAULT = 3'h7,
    WTS_ERROR     = 3'h5
  } wts_state_t;
endpackage : wts_pkg

// *** core/wts_flash_if.sv ***
// Interface carrying the flash timebase between sequencer and prescaler
`timescale 1ns/1ps
`default_nettype none
interface wts_flash_if;
  logic run;   // Timebase running
  logic phase; // High during lit half of a flash period
  modport ctrl  (output run, input phase);
  modport timer (input run, output phase);
endinterface : wts_flash_if
`default_nettype wire

// *** core/wts_flash_timer.sv ***
// One-second half-duty flash timebase from the system clock
`timescale 1ns/1ps
`default_nettype none
module wts_flash_timer #(
  parameter int unsigned HALF_CYC = wts_pkg::HALF_FLASH_CYC
) (
  // Clock and reset
  input  wire logic      clock,
  input  wire logic      rst_b,
  input  wire logic      clk_en,
  // Timebase
  wts_flash_if.timer     fl
);
  logic [wts_pkg::CNT_W-1:0] cnt_q;
  logic                      phase_q;

  // Prescaler, toggles phase every half period
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= '0;
      phase_q <= wts_pkg::FLASH_RESET;
    end else if (clk_en) begin
      if (!fl.run) begin
        cnt_q   <= '0;
        phase_q <= 1'b1; // Each run starts lit; the red flash keeps the charge phase
      end else if (cnt_q == HALF_CYC[wts_pkg::CNT_W-1:0] - 32'h1) begin
        cnt_q   <= '0;
        phase_q <= ~phase_q;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign fl.phase = phase_q;
endmodule : wts_flash_timer
`default_nettype wire

// *** core/wts_sequencer.sv ***
// Status sequencer of a wireless power transmitter with LED indication
// Operation
// - After power-up, light only green about half a second, then standby.
// - In standby both LEDs stay dark.
// - Receiver detected in standby moves to negotiation before any power.
// - Transmit enable only with receiver present, never in init or standby.
// - While charging, green flashes once per second, red dark.
// - Foreign object while charging aborts power, red flashes once per second.
// - Foreign-object fault persists until receiver removed.
// - Other errors abort charging; red steadily on until receiver removed.
// - Errors are communication, over-voltage, -current, -power, -temperature on either side.
// - Power requests stopping during a transaction terminate it and stop power.
// - No-more-power enters charge-complete, green steady until removal.
// - Receiver removal returns to standby from any later state.
`timescale 1ns/1ps
`default_nettype none
module wts_sequencer #(
  parameter int unsigned INIT_CYC    = wts_pkg::INIT_CYCLES,
  parameter int unsigned HALF_CYC    = wts_pkg::HALF_FLASH_CYC,
  parameter int unsigned TIMEOUT_CYC = wts_pkg::REQ_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Receiver events (asynchronous pins)
  input  wire logic rx_present,
  input  wire logic rx_config_done,
  input  wire logic rx_power_req,
  input  wire logic rx_end_power,
  input  wire logic comm_error,
  // Fault reports (asynchronous pins)
  input  wire logic fod_detect,
  input  wire logic rx_fault,
  input  wire logic tx_fault,
  // Outputs
  output logic      tx_enable,
  output logic      led_green,
  output logic      led_red,
  output wts_pkg::wts_state_t state
);
  localparam int NS = 8;

  // Two-stage synchronisers for every pin input
  logic [NS-1:0] pin_raw, sync1_q, sync2_q;
  assign pin_raw = {rx_present, rx_config_done, rx_power_req, rx_end_power,
                    comm_error, fod_detect, rx_fault, tx_fault};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic present, cfg_done, req_lvl, end_pwr, cerr, fod, rfault, tfault;
  assign {present, cfg_done, req_lvl, end_pwr, cerr, fod, rfault, tfault} = sync2_q;

  // Rising edge of the power request line marks one request
  logic req_prev_q, req_pulse;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_prev_q <= 1'b0;
    end else if (clk_en) begin
      req_prev_q <= req_lvl;
    end
  end
  assign req_pulse = req_lvl & ~req_prev_q;

  // Error classes that lead to the steady-red state
  function automatic logic is_error(input logic c, input logic r, input logic t);
    return c | r | t;
  endfunction

  wts_pkg::wts_state_t state_q, state_d;
  logic [wts_pkg::CNT_W-1:0] init_cnt_q, req_cnt_q;
  logic init_done, req_timeout, in_txn;

  assign init_done   = (init_cnt_q == INIT_CYC[wts_pkg::CNT_W-1:0] - 32'h1);
  assign req_timeout = (req_cnt_q == TIMEOUT_CYC[wts_pkg::CNT_W-1:0] - 32'h1);
  assign in_txn      = (state_q == wts_pkg::WTS_NEGOTIATE) || (state_q == wts_pkg::WTS_CHARGE);

  // Initialization timer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_q <= '0;
    end else if (clk_en) begin
      if (state_q == wts_pkg::WTS_INIT && !init_done) begin
        init_cnt_q <= init_cnt_q + 32'h1;
      end
    end
  end

  // Power request watchdog during the transaction
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      req_cnt_q <= '0;
    end else if (clk_en) begin
      if (!in_txn || req_pulse) begin
        req_cnt_q <= '0;
      end else if (!req_timeout) begin
        req_cnt_q <= req_cnt_q + 32'h1;
      end
    end
  end

  // Next-state logic
  always_comb begin
    state_d = state_q;
    case (state_q)
      wts_pkg::WTS_INIT: begin
        if (init_done) begin
          state_d = wts_pkg::WTS_STANDBY;
        end
      end
      wts_pkg::WTS_STANDBY: begin
        if (present) begin
          state_d = wts_pkg::WTS_NEGOTIATE;
        end
      end
      wts_pkg::WTS_NEGOTIATE: begin
        if (!present || req_timeout) begin
          state_d = wts_pkg::WTS_STANDBY;
        end else if (is_error(cerr, rfault, tfault)) begin
          state_d = wts_pkg::WTS_ERROR;
        end else if (cfg_done) begin
          state_d = wts_pkg::WTS_CHARGE;
        end
      end
      wts_pkg::WTS_CHARGE: begin
        if (!present || req_timeout) begin
          state_d = wts_pkg::WTS_STANDBY;
        end else if (fod) begin
          state_d = wts_pkg::WTS_FOD_FAULT;
        end else if (is_error(cerr, rfault, tfault)) begin
          state_d = wts_pkg::WTS_ERROR;
        end else if (end_pwr) begin
          state_d = wts_pkg::WTS_COMPLETE;
        end
      end
      wts_pkg::WTS_COMPLETE, wts_pkg::WTS_FOD_FAULT, wts_pkg::WTS_ERROR: begin
        if (!present) begin
          state_d = wts_pkg::WTS_STANDBY;
        end
      end
      default: state_d = wts_pkg::WTS_INIT;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= wts_pkg::WTS_INIT;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Flash timebase
  wts_flash_if fl ();
  logic flashing;
  assign flashing = (state_q == wts_pkg::WTS_CHARGE) || (state_q == wts_pkg::WTS_FOD_FAULT);
  assign fl.run   = flashing;
  wts_flash_timer #(.HALF_CYC(HALF_CYC)) u_flash (
    .clock  (clock),
    .rst_b  (rst_b),
    .clk_en (clk_en),
    .fl     (fl.timer)
  );

  // Registered outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_enable <= 1'b0;
      led_green <= 1'b0;
      led_red   <= 1'b0;
    end else if (clk_en) begin
      // Power only in negotiation/charge with receiver present
      tx_enable <= present && (state_d == wts_pkg::WTS_NEGOTIATE || state_d == wts_pkg::WTS_CHARGE);
      case (state_q)
        wts_pkg::WTS_INIT: begin
          led_green <= 1'b1;
          led_red   <= 1'b0;
        end
        wts_pkg::WTS_CHARGE: begin
          led_green <= fl.phase;
          led_red   <= 1'b0;
        end
        wts_pkg::WTS_COMPLETE: begin
          led_green <= 1'b1;
          led_red   <= 1'b0;
        end
        wts_pkg::WTS_FOD_FAULT: begin
          led_green <= 1'b0;
          led_red   <= fl.phase;
        end
        wts_pkg::WTS_ERROR: begin
          led_green <= 1'b0;
          led_red   <= 1'b1;
        end
        default: begin
          led_green <= 1'b0;
          led_red   <= 1'b0;
        end
      endcase
    end
  end

  assign state = state_q;
endmodule : wts_sequencer
`default_nettype wire

// *** testbench/wts_sequencer_props.sv ***
// Assertion checker on the status sequencer ports
`timescale 1ns/1ps
`default_nettype none
module wts_sequencer_props (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst_b,
  // Observed outputs
  input wire logic                tx_enable,
  input wire logic                led_green,
  input wire logic                led_red,
  input wire wts_pkg::wts_state_t state
);
  // State decodes
  wire logic ini = state == wts_pkg::WTS_INIT;
  wire logic sb  = state == wts_pkg::WTS_STANDBY;
  wire logic ng  = state == wts_pkg::WTS_NEGOTIATE;
  wire logic ch  = state == wts_pkg::WTS_CHARGE;
  wire logic cp  = state == wts_pkg::WTS_COMPLETE;
  wire logic fd  = state == wts_pkg::WTS_FOD_FAULT;
  wire logic er  = state == wts_pkg::WTS_ERROR;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Dark half of a red flash, then lit again
  sequence s_dark; !led_red [*8]; endsequence
  sequence s_back; led_red || !fd; endsequence

  property p_init_led; ini && $past(ini) && $past(rst_b) |-> led_green && !led_red; endproperty
  property p_sb_dark; sb && $past(sb) |-> !led_green && !led_red; endproperty
  property p_sb_next; $past(sb) |-> sb || ng; endproperty
  property p_ch_from; ch && !$past(ch) |-> $past(ng); endproperty
  property p_idle_off; ini || sb |-> !tx_enable; endproperty
  property p_ch_red; ch && $past(ch) |-> !led_red; endproperty
  property p_fd_flash; $fell(led_red) && fd |-> s_dark ##1 s_back; endproperty
  property p_abort; fd || er |-> !tx_enable; endproperty
  property p_er_red; er && $past(er) |-> led_red && !led_green; endproperty
  property p_cp_grn; cp && $past(cp) |-> led_green && !led_red; endproperty
  property p_hold; $past(fd) || $past(er) || $past(cp) |-> state == $past(state) || sb; endproperty

  a_init_led: assert property (p_init_led) else $error("init lamp wrong");
  a_sb_dark: assert property (p_sb_dark) else $error("standby lamp lit");
  a_sb_next: assert property (p_sb_next) else $error("standby exit wrong");
  a_ch_from: assert property (p_ch_from) else $error("charge skipped talk");
  a_idle_off: assert property (p_idle_off) else $error("power while idle");
  a_ch_red: assert property (p_ch_red) else $error("red lit in charge");
  a_fd_flash: assert property (p_fd_flash) else $error("red flash wrong");
  a_abort: assert property (p_abort) else $error("power not aborted");
  a_er_red: assert property (p_er_red) else $error("error lamp wrong");
  a_cp_grn: assert property (p_cp_grn) else $error("done lamp wrong");
  a_hold: assert property (p_hold) else $error("hold state left");
endmodule // wts_sequencer_props
`default_nettype wire

// *** testbench/wts_rx_model.sv ***
// Receiver model driving the event pins of the sequencer
`timescale 1ns/1ps
`default_nettype none
module wts_rx_model (
  // Clock and transmitter feedback
  input  wire logic       clock,
  input  wire logic       tx_enable,
  // Scenario controls
  input  wire logic       place,
  input  wire logic       quiet,
  input  wire logic       done,
  input  wire logic       fod_in,
  input  wire logic [1:0] err_in,
  // Receiver pins
  output logic            rx_present,
  output logic            rx_config_done,
  output logic            rx_power_req,
  output logic            rx_end_power,
  output logic            comm_error,
  output logic            fod_detect,
  output logic            rx_fault
);
  logic [3:0] tick_q = 4'h0;
  // Request spacing counter, off the falling edge
  always @(negedge clock) begin
    tick_q <= place ? tick_q + 4'h1 : 4'h0;
  end
  // Pin levels
  assign rx_present     = place;
  assign rx_config_done = place && tx_enable;
  assign rx_power_req   = place && !quiet && tick_q == 4'hf;
  assign rx_end_power   = place && done;
  assign comm_error     = err_in[0];
  assign rx_fault       = err_in[1];
  assign fod_detect     = fod_in;
endmodule // wts_rx_model
`default_nettype wire

// *** testbench/wts_sequencer_tb.sv ***
// Testbench for the wireless transmit status sequencer
`timescale 1ns/1ps
`default_nettype none
module wts_sequencer_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic tx_fault = 1'b0;
  logic place = 1'b0;
  logic quiet = 1'b0;
  logic done = 1'b0;
  logic fod_in = 1'b0;
  logic [1:0] err_in = 2'h0;
  logic tx_enable, led_green, led_red, rx_present, rx_config_done;
  logic rx_power_req, rx_end_power, comm_error, fod_detect, rx_fault;
  wts_pkg::wts_state_t state;
  int miscompares = 0;
  int total_checks = 0;
  int rg, rr;

  // Clock, 4 ns period
  always #2 clock = ~clock;

  wts_sequencer #(.INIT_CYC(20), .HALF_CYC(8), .TIMEOUT_CYC(50)) dut_u (
    .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .rx_present(rx_present),
    .rx_config_done(rx_config_done), .rx_power_req(rx_power_req), .rx_end_power(rx_end_power),
    .comm_error(comm_error), .fod_detect(fod_detect), .rx_fault(rx_fault), .tx_fault(tx_fault),
    .tx_enable(tx_enable), .led_green(led_green), .led_red(led_red), .state(state));

  wts_rx_model rx_u (
    .clock(clock), .tx_enable(tx_enable), .place(place), .quiet(quiet), .done(done),
    .fod_in(fod_in), .err_in(err_in), .rx_present(rx_present), .rx_config_done(rx_config_done),
    .rx_power_req(rx_power_req), .rx_end_power(rx_end_power), .comm_error(comm_error),
    .fod_detect(fod_detect), .rx_fault(rx_fault));

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a state
  task automatic wait_st(input wts_pkg::wts_state_t s, input int lim);
    int n;
    n = 0;
    while (state !== s && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk(state, s);
    if (state !== s) summarize();
  endtask

  // Count lamp turn-ons over a stretch
  task automatic watch;
    logic g, r;
    @(negedge clock);
    g = led_green;
    r = led_red;
    rg = 0;
    rr = 0;
    repeat (32) begin
      @(negedge clock);
      rg += int'(led_green && !g);
      rr += int'(led_red && !r);
      g = led_green;
      r = led_red;
    end
  endtask

  task automatic t_init;
    chk({led_green, led_red, tx_enable}, 3'h4);
    repeat (16) @(negedge clock);
    chk(state, wts_pkg::WTS_INIT);
    wait_st(wts_pkg::WTS_STANDBY, 40);
    watch();
    chk(3'(rg + rr), 3'h0);
    chk({led_green, led_red, tx_enable}, 3'h0);
  endtask

  task automatic t_go;
    place = 1'b1;
    wait_st(wts_pkg::WTS_NEGOTIATE, 10);
    wait_st(wts_pkg::WTS_CHARGE, 20);
    watch();
    chk(3'(rg), 3'h2);
    chk({led_red, tx_enable}, 3'h1);
  endtask

  task automatic t_off;
    {place, done, fod_in, quiet, tx_fault, err_in} = 7'h0;
    wait_st(wts_pkg::WTS_STANDBY, 10);
  endtask

  task automatic t_done;
    t_go();
    done = 1'b1;
    wait_st(wts_pkg::WTS_COMPLETE, 10);
    watch();
    chk({led_green, 2'(rg)}, 3'h4);
    t_off();
  endtask

  task automatic t_fod;
    t_go();
    fod_in = 1'b1;
    wait_st(wts_pkg::WTS_FOD_FAULT, 10);
    fod_in = 1'b0;
    watch();
    chk({tx_enable, 2'(rr)}, 3'h2);
    chk(state, wts_pkg::WTS_FOD_FAULT);
    t_off();
  endtask

  task automatic t_err(input int k);
    t_go();
    {tx_fault, err_in} = 3'h1 << k;
    wait_st(wts_pkg::WTS_ERROR, 10);
    {tx_fault, err_in} = 3'h0;
    watch();
    chk({led_green, led_red, tx_enable}, 3'h2);
    chk(state, wts_pkg::WTS_ERROR);
    t_off();
  endtask

  // Error while still negotiating goes straight to steady red
  task automatic t_neg_err;
    {err_in, place} = 3'h3;
    wait_st(wts_pkg::WTS_NEGOTIATE, 10);
    wait_st(wts_pkg::WTS_ERROR, 10);
    @(negedge clock);
    chk({led_green, led_red, tx_enable}, 3'h2);
    t_off();
  endtask

  task automatic t_quiet;
    t_go();
    quiet = 1'b1;
    wait_st(wts_pkg::WTS_STANDBY, 80);
    chk(3'(tx_enable), 3'h0);
    t_off();
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    t_init();
    t_done();
    t_fod();
    for (int k = 0; k < 3; k++) begin
      t_err(k);
    end
    t_neg_err();
    t_quiet();
    summarize();
  end
endmodule // wts_sequencer_tb

bind wts_sequencer wts_sequencer_props chk_u (.clock(clock), .rst_b(rst_b), .tx_enable(tx_enable),
  .led_green(led_green), .led_red(led_red), .state(state));
`default_nettype wire
